// >>> sdcc_pkg.sv
package sdcc_pkg;

  // ********************************************************************
  // Register map, word aligned byte addresses.
  // ********************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CURR   = 8'h04;
  localparam logic [7:0] ADDR_DELAY  = 8'h08;
  localparam logic [7:0] ADDR_USERID = 8'h0c;
  localparam logic [7:0] ADDR_FAULT  = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_POS    = 8'h18;

  // ********************************************************************
  // Field positions in the control, current and fault registers.
  // ********************************************************************
  localparam int CTRL_USTEP_LSB  = 0;
  localparam int CTRL_DIR_BIT    = 8;
  localparam int CTRL_ENPOL_BIT  = 9;
  localparam int CTRL_FMT_LSB    = 12;
  localparam int CTRL_FILT_LSB   = 16;
  localparam int CURR_HOLD_LSB   = 8;
  localparam int FAULT_INJ_LSB   = 8;

  // ********************************************************************
  // Reset values.
  // ********************************************************************
  localparam logic [4:0]  RST_USTEP    = 5'h08;
  localparam logic        RST_DIR      = 1'b1;
  localparam logic        RST_ENPOL    = 1'b1;
  localparam logic [1:0]  RST_FMT      = 2'h0;
  localparam logic [3:0]  RST_FILT     = 4'h0;
  localparam logic [6:0]  RST_RUN_PCT  = 7'h19;
  localparam logic [6:0]  RST_HOLD_PCT = 7'h05;
  localparam logic [7:0]  RST_DLY_HI   = 8'h01;
  localparam logic [7:0]  RST_DLY_LO   = 8'hf4;
  // Default user tag; the value is arbitrary.
  localparam logic [23:0] RST_USERID   = 24'h515253;

  // ********************************************************************
  // Encodings.
  // ********************************************************************
  localparam logic [1:0] FMT_STEP_DIR = 2'h0;
  localparam logic [1:0] FMT_UP_DOWN  = 2'h1;
  localparam logic [1:0] FMT_QUAD     = 2'h2;
  localparam logic [5:0] FAULT_CKSUM  = 6'h04;
  localparam logic [5:0] FAULT_SECTOR = 6'h08;
  localparam logic [5:0] FAULT_DEFAULTS = 6'h10;
  localparam logic [5:0] FAULT_DATA   = 6'h20;
  localparam int NUM_USTEP = 20;
  localparam int NUM_FILT = 10;

  // ********************************************************************
  // Timing.
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam logic [16:0] CYC_PER_MS = 17'(MS_NS / CLK_PERIOD_NS);
  localparam int FILT_NS [NUM_FILT] = '{50, 150, 200, 300, 500, 900,
                                        1700, 3300, 5500, 12900};
  localparam logic [8:0] USTEP_VAL [NUM_USTEP] = '{
    9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080,
    9'h100, 9'h0b4, 9'h06c, 9'h07f, 9'h005, 9'h00a, 9'h019, 9'h032,
    9'h064, 9'h07d, 9'h0c8, 9'h0fa};

  typedef enum {
    SDCC_RUN,
    SDCC_WAIT,
    SDCC_HOLD
  } sdcc_cur_t;

endpackage

// >>> sdcc_core.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sdcc_core (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  input  wire logic        step_in_a,
  input  wire logic        step_in_b,
  input  wire logic        enable_in,
  input  wire logic [5:0]  fault_event,
  output logic             step_pulse,
  output logic             step_dir,
  output logic [8:0]       step_increment,
  output logic [6:0]       current_pct,
  output logic             stage_enable,
  output logic             hold_active
);

  // ********************************************************************
  // Configuration registers.
  // ********************************************************************
  logic [4:0]  microstep_select_r;
  logic        direction_invert_cfg_r;
  logic        enable_polarity_r;
  logic [1:0]  step_input_format_r;
  logic [3:0]  step_filter_select_r;
  logic [6:0]  run_current_pct_r;
  logic [6:0]  hold_current_pct_r;
  logic [7:0]  hold_delay_high_byte_r;
  logic [7:0]  hold_delay_low_byte_r;
  logic [23:0] user_tag_r;
  logic [5:0]  fault_code_r;
  logic [31:0] position_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        wr_hit;
  logic        wr_cfg;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rdata_r;
  assign avs_response    = 2'h0;
  assign wr_hit          = avs_write & ack_r;
  assign wr_cfg          = wr_hit & (avs_address != sdcc_pkg::ADDR_FAULT)
                           & (avs_address != sdcc_pkg::ADDR_STATUS)
                           & (avs_address != sdcc_pkg::ADDR_POS);

  // ********************************************************************
  // Bus handshake: one wait cycle per access.
  // ********************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // ********************************************************************
  // Register writes.
  // ********************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      microstep_select_r     <= sdcc_pkg::RST_USTEP;
      direction_invert_cfg_r <= sdcc_pkg::RST_DIR;
      enable_polarity_r      <= sdcc_pkg::RST_ENPOL;
      step_input_format_r    <= sdcc_pkg::RST_FMT;
      step_filter_select_r   <= sdcc_pkg::RST_FILT;
      run_current_pct_r      <= sdcc_pkg::RST_RUN_PCT;
      hold_current_pct_r     <= sdcc_pkg::RST_HOLD_PCT;
      hold_delay_high_byte_r <= sdcc_pkg::RST_DLY_HI;
      hold_delay_low_byte_r  <= sdcc_pkg::RST_DLY_LO;
      user_tag_r             <= sdcc_pkg::RST_USERID;
    end else if (wr_hit) begin
      case (avs_address)
        sdcc_pkg::ADDR_CTRL: begin
          if (avs_byteenable[0] &&
              avs_writedata[4:0] < 5'(sdcc_pkg::NUM_USTEP)) begin
            microstep_select_r <= avs_writedata[4:0];
          end
          if (avs_byteenable[1]) begin
            direction_invert_cfg_r <= avs_writedata[sdcc_pkg::CTRL_DIR_BIT];
            enable_polarity_r <= avs_writedata[sdcc_pkg::CTRL_ENPOL_BIT];
            if (avs_writedata[13:12] != 2'h3) begin
              step_input_format_r <= avs_writedata[13:12];
            end
          end
          if (avs_byteenable[2] &&
              avs_writedata[19:16] < 4'(sdcc_pkg::NUM_FILT)) begin
            step_filter_select_r <= avs_writedata[19:16];
          end
        end
        sdcc_pkg::ADDR_CURR: begin
          if (avs_byteenable[0] && avs_writedata[6:0] <= 7'h64) begin
            run_current_pct_r <= avs_writedata[6:0];
          end
          if (avs_byteenable[1] && avs_writedata[14:8] <= 7'h64) begin
            hold_current_pct_r <= avs_writedata[14:8];
          end
        end
        sdcc_pkg::ADDR_DELAY: begin
          if (avs_byteenable[0]) begin
            hold_delay_low_byte_r <= avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            hold_delay_high_byte_r <= avs_writedata[15:8];
          end
        end
        sdcc_pkg::ADDR_USERID: begin
          for (int i = 0; i < 3; i++) begin
            if (avs_byteenable[i] && avs_writedata[8*i +: 8] >= 8'h20 &&
                avs_writedata[8*i +: 8] <= 8'h7e) begin
              user_tag_r[8*i +: 8] <= avs_writedata[8*i +: 8];
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ********************************************************************
  // Fault code: fault_event bits 2 to 5 latch, parameter writes clear, set wins.
  // ********************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fault_code_r <= 6'h00;
    end else begin
      fault_code_r <= (wr_cfg ? 6'h00 : fault_code_r)
                      | (fault_event & (sdcc_pkg::FAULT_CKSUM
                      | sdcc_pkg::FAULT_SECTOR | sdcc_pkg::FAULT_DEFAULTS
                      | sdcc_pkg::FAULT_DATA));
    end
  end

  // ********************************************************************
  // Step input filter.
  // ********************************************************************
  logic [1:0]  filt_r;
  logic [1:0]  raw;
  logic [10:0] filt_cnt_r [2];
  logic [10:0] filt_min;

  assign raw = {step_in_b, step_in_a};

  always_comb begin
    filt_min = 11'h001;
    for (int k = 0; k < sdcc_pkg::NUM_FILT; k++) begin
      if (step_filter_select_r == 4'(k)) begin
        filt_min = 11'((sdcc_pkg::FILT_NS[k] + sdcc_pkg::CLK_PERIOD_NS - 1)
                       / sdcc_pkg::CLK_PERIOD_NS);
      end
    end
  end

  generate
    for (genvar g = 0; g < 2; g++) begin : g_filt
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          filt_r[g]     <= 1'b0;
          filt_cnt_r[g] <= 11'h000;
        end else if (raw[g] == filt_r[g]) begin
          filt_cnt_r[g] <= 11'h000;
        end else if (filt_cnt_r[g] + 11'h001 >= filt_min) begin
          filt_r[g]     <= raw[g];
          filt_cnt_r[g] <= 11'h000;
        end else begin
          filt_cnt_r[g] <= filt_cnt_r[g] + 11'h001;
        end
      end
    end
  endgenerate

  // ********************************************************************
  // Step decoding.
  // ********************************************************************
  logic [1:0] prev_r;
  logic       dec_step;
  logic       dec_dir;
  logic       enabled;

  assign enabled = (enable_in == enable_polarity_r);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prev_r <= 2'h0;
    end else begin
      prev_r <= filt_r;
    end
  end

  always_comb begin
    dec_step = 1'b0;
    dec_dir  = 1'b0;
    case (step_input_format_r)
      sdcc_pkg::FMT_STEP_DIR: begin
        dec_step = filt_r[0] & ~prev_r[0];
        dec_dir  = filt_r[1];
      end
      sdcc_pkg::FMT_UP_DOWN: begin
        dec_step = (filt_r[0] & ~prev_r[0]) ^ (filt_r[1] & ~prev_r[1]);
        dec_dir  = filt_r[0] & ~prev_r[0];
      end
      sdcc_pkg::FMT_QUAD: begin
        dec_step = (filt_r != prev_r) && (filt_r != ~prev_r);
        dec_dir  = prev_r[0] ^ filt_r[1];
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      step_pulse     <= 1'b0;
      step_dir       <= 1'b0;
      step_increment <= sdcc_pkg::USTEP_VAL[sdcc_pkg::RST_USTEP];
      position_r     <= 32'h0;
    end else begin
      step_pulse     <= dec_step & enabled;
      step_increment <= sdcc_pkg::USTEP_VAL[microstep_select_r];
      if (dec_step & enabled) begin
        step_dir <= dec_dir ^ ~direction_invert_cfg_r;
        if (dec_dir ^ ~direction_invert_cfg_r) begin
          position_r <= position_r
                        + {23'h0, sdcc_pkg::USTEP_VAL[microstep_select_r]};
        end else begin
          position_r <= position_r
                        - {23'h0, sdcc_pkg::USTEP_VAL[microstep_select_r]};
        end
      end
    end
  end

  // ********************************************************************
  // Hold current delay.
  // ********************************************************************
  sdcc_pkg::sdcc_cur_t cur_r;
  logic [16:0] ms_cnt_r;
  logic [15:0] ms_left_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cur_r     <= sdcc_pkg::SDCC_HOLD;
      ms_cnt_r  <= 17'h0;
      ms_left_r <= 16'h0;
    end else if (dec_step & enabled) begin
      cur_r     <= sdcc_pkg::SDCC_WAIT;
      ms_cnt_r  <= 17'h0;
      ms_left_r <= {hold_delay_high_byte_r, hold_delay_low_byte_r};
    end else begin
      case (cur_r)
        sdcc_pkg::SDCC_WAIT: begin
          if (ms_left_r == 16'h0) begin
            cur_r <= sdcc_pkg::SDCC_HOLD;
          end else if (ms_cnt_r == sdcc_pkg::CYC_PER_MS - 17'h1) begin
            ms_cnt_r  <= 17'h0;
            ms_left_r <= ms_left_r - 16'h1;
          end else begin
            ms_cnt_r <= ms_cnt_r + 17'h1;
          end
        end
        sdcc_pkg::SDCC_RUN: begin
          cur_r <= sdcc_pkg::SDCC_WAIT;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hold_active  <= 1'b1;
      current_pct  <= sdcc_pkg::RST_HOLD_PCT;
      stage_enable <= 1'b0;
    end else begin
      hold_active <= (cur_r == sdcc_pkg::SDCC_HOLD);
      if (cur_r == sdcc_pkg::SDCC_HOLD) begin
        current_pct  <= hold_current_pct_r;
        stage_enable <= enabled && hold_current_pct_r != 7'h0;
      end else begin
        current_pct  <= run_current_pct_r;
        stage_enable <= enabled;
      end
    end
  end

  // ********************************************************************
  // Read data.
  // ********************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_r <= 32'h0;
    end else if (avs_read & ~ack_r) begin
      case (avs_address)
        sdcc_pkg::ADDR_CTRL: rdata_r <= {12'h0, step_filter_select_r,
          2'h0, step_input_format_r, 2'h0, enable_polarity_r,
          direction_invert_cfg_r, 3'h0, microstep_select_r};
        sdcc_pkg::ADDR_CURR: rdata_r <= {17'h0, hold_current_pct_r,
          1'b0, run_current_pct_r};
        sdcc_pkg::ADDR_DELAY: rdata_r <= {16'h0, hold_delay_high_byte_r,
          hold_delay_low_byte_r};
        sdcc_pkg::ADDR_USERID: rdata_r <= {8'h0, user_tag_r};
        sdcc_pkg::ADDR_FAULT: rdata_r <= {26'h0, fault_code_r};
        sdcc_pkg::ADDR_STATUS: rdata_r <= {27'h0, enabled, stage_enable,
          hold_active, filt_r};
        sdcc_pkg::ADDR_POS: rdata_r <= position_r;
        default: rdata_r <= 32'h0;
      endcase
    end
  end

endmodule // sdcc_core

// >>> sdcc_core_assertions.sv
`timescale 1ns/1ps
// *****************************************************
// Port checks for the stepper drive configuration core.
// *****************************************************
module sdcc_core_assertions (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        step_pulse,
  input wire logic [8:0]  step_increment,
  input wire logic [6:0]  current_pct,
  input wire logic        stage_enable,
  input wire logic        hold_active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_wait_first_cycle: assert property (
    (avs_read || avs_write) && !$past(avs_read || avs_write)
      |-> avs_waitrequest) else $error("no wait on first cycle");
  a_wait_one_cycle: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait held too long");
  a_resp_okay: assert property (avs_response == 2'h0)
    else $error("response not okay");
  a_read_data_holds: assert property (
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_reset_values: assert property (
    $fell(reset) |-> hold_active && !stage_enable && !step_pulse
      && current_pct == 7'h05 && step_increment == 9'h100)
    else $error("output not at reset value");
  a_increment_legal: assert property (
    step_increment inside {9'h001, 9'h002, 9'h004, 9'h008, 9'h010,
      9'h020, 9'h040, 9'h080, 9'h100, 9'h0b4, 9'h06c, 9'h07f, 9'h005,
      9'h00a, 9'h019, 9'h032, 9'h064, 9'h07d, 9'h0c8, 9'h0fa})
    else $error("illegal microstep increment");
  a_step_runs: assert property (
    step_pulse |-> ##[0:3] (!hold_active && stage_enable))
    else $error("step did not restore run current");
  a_zero_hold_off: assert property (
    (hold_active && current_pct == 7'h00) [*2] |-> !stage_enable)
    else $error("stage on at zero hold current");
  a_pulse_single: assert property (step_pulse |=> !step_pulse)
    else $error("step pulse too long");
endmodule // sdcc_core_assertions

bind sdcc_core sdcc_core_assertions u_chk (
  .ref_clk, .reset, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .avs_response, .step_pulse, .step_increment,
  .current_pct, .stage_enable, .hold_active
);

// >>> sdcc_motion_model.sv
`timescale 1ns/1ps
// ***********************************************
// Motion controller model driving the step inputs.
// ***********************************************
module sdcc_motion_model (
  input  wire logic ref_clk,
  output logic      step_in_a,
  output logic      step_in_b
);
  initial begin
    step_in_a = 1'b0;
    step_in_b = 1'b0;
  end
  // Sends one step, or in quadrature format one full cycle of four steps; hi is each phase length in cycles.
  task automatic send(input logic [1:0] f, input logic fwd, input int hi);
    logic [3:0] p;
    logic [3:0] q;
    p = 4'h3;
    q = 4'h6;
    @(posedge ref_clk);
    if (f == 2'h2) begin
      for (int i = 0; i < 3; i++) begin
        if (i > 0)
          repeat (hi) @(posedge ref_clk);
        step_in_a <= fwd ? q[i] : p[i];
        step_in_b <= fwd ? p[i] : q[i];
      end
    end else if (f == 2'h0) begin
      step_in_b <= fwd;
      repeat (hi) @(posedge ref_clk);
      step_in_a <= 1'b1;
    end else if (fwd) begin
      step_in_a <= 1'b1;
    end else begin
      step_in_b <= 1'b1;
    end
    repeat (hi) @(posedge ref_clk);
    step_in_a <= 1'b0;
    step_in_b <= 1'b0;
    repeat (hi) @(posedge ref_clk);
  endtask
endmodule // sdcc_motion_model

// >>> tb_stepper_drive_config_core.sv
`timescale 1ns/1ps
// ***************************************
// Testbench for the configuration core.
// ***************************************
module tb_stepper_drive_config_core;
  logic        ref_clk        = 1'b0;
  logic        reset          = 1'b1;
  logic [7:0]  avs_address    = 8'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        enable_in      = 1'b1;
  logic [5:0]  fault_event    = 6'h00;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        step_in_a;
  logic        step_in_b;
  logic        step_pulse;
  logic        step_dir;
  logic [8:0]  step_increment;
  logic [6:0]  current_pct;
  logic        stage_enable;
  logic        hold_active;
  logic [31:0] rd;
  int          err_total = 0;
  int          checks    = 0;
  int          pulses    = 0;
  int          n;
  logic [8:0]  inc_tab [20] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010,
    9'h020, 9'h040, 9'h080, 9'h100, 9'h0b4, 9'h06c, 9'h07f, 9'h005,
    9'h00a, 9'h019, 9'h032, 9'h064, 9'h07d, 9'h0c8, 9'h0fa};
  int          fcyc [10] = '{5, 15, 20, 30, 50, 90, 170, 330, 550, 1290};

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (step_pulse === 1'b1)
      pulses <= pulses + 1;

  sdcc_core dut (
    .ref_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .step_in_a, .step_in_b, .enable_in, .fault_event, .step_pulse,
    .step_dir, .step_increment, .current_pct, .stage_enable, .hold_active
  );
  sdcc_motion_model mdl (.ref_clk, .step_in_a, .step_in_b);

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && k < 20) begin
      @(posedge ref_clk);
      k++;
    end
    chk("bus answer", 32'h0, 32'(k == 20));
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rdc(input string w, input logic [7:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(w, e, rd);
  endtask

  task automatic setc(input logic [4:0] m, input logic d, input logic p,
                      input logic [1:0] f, input logic [3:0] l);
    bus(1'b1, sdcc_pkg::ADDR_CTRL, {12'h0, l, 2'h0, f, 2'h0, p, d, 3'h0, m});
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic step1(input logic [1:0] f, input logic fwd, input int hi);
    int p0;
    p0 = pulses;
    mdl.send(f, fwd, hi);
    repeat (10) @(negedge ref_clk);
    n = pulses - p0;
  endtask

  task automatic fev(input logic [5:0] v);
    @(posedge ref_clk);
    fault_event <= v;
    @(posedge ref_clk);
    fault_event <= 6'h00;
  endtask

  task automatic t_reset();
    chk("hold_active", 32'h1, 32'(hold_active));
    chk("current_pct", 32'h05, 32'(current_pct));
    chk("step_increment", 32'h100, 32'(step_increment));
    rdc("ctrl", sdcc_pkg::ADDR_CTRL, 32'h0308);
    rdc("curr", sdcc_pkg::ADDR_CURR, 32'h0519);
    rdc("delay", sdcc_pkg::ADDR_DELAY, 32'h01f4);
    rdc("tag", sdcc_pkg::ADDR_USERID, {8'h0, sdcc_pkg::RST_USERID});
    bus(1'b1, sdcc_pkg::ADDR_USERID, 32'h00414243);
    rdc("tag", sdcc_pkg::ADDR_USERID, 32'h00414243);
    rdc("unmapped", 8'h1c, 32'h0);
  endtask

  task automatic t_microstep_select();
    logic [31:0] p;
    for (int i = 0; i < 20; i++) begin
      setc(5'(i), 1'b1, 1'b1, 2'h0, 4'h0);
      chk("increment", 32'(inc_tab[i]), 32'(step_increment));
    end
    setc(5'h14, 1'b1, 1'b1, 2'h0, 4'h0);
    chk("increment kept", 32'h0fa, 32'(step_increment));
    setc(5'h04, 1'b1, 1'b1, 2'h0, 4'h0);
    bus(1'b0, sdcc_pkg::ADDR_POS, 32'h0);
    p = rd;
    step1(2'h0, 1'b1, 10);
    step1(2'h0, 1'b1, 10);
    rdc("position", sdcc_pkg::ADDR_POS, p + 32'h20);
  endtask

  task automatic t_fmt();
    for (int f = 0; f < 3; f++)
      for (int d = 0; d < 2; d++) begin
        setc(5'h08, 1'b1, 1'b1, 2'(f), 4'h0);
        step1(2'(f), d[0], 10);
        chk("step", 32'(f == 2 ? 4 : 1), 32'(n));
        chk("step_dir", 32'(d), 32'(step_dir));
      end
    setc(5'h08, 1'b0, 1'b1, 2'h0, 4'h0);
    step1(2'h0, 1'b1, 10);
    chk("inverted dir", 32'h0, 32'(step_dir));
  endtask

  task automatic t_filter();
    for (int i = 0; i < 10; i++) begin
      setc(5'h08, 1'b1, 1'b1, 2'h0, 4'(i));
      step1(2'h0, 1'b1, fcyc[i] - 2);
      chk("short pulse", 32'h0, 32'(n));
      step1(2'h0, 1'b1, fcyc[i] + 4);
      chk("long pulse", 32'h1, 32'(n));
    end
  endtask

  task automatic t_enable();
    setc(5'h08, 1'b1, 1'b1, 2'h0, 4'h0);
    @(posedge ref_clk);
    enable_in <= 1'b0;
    step1(2'h0, 1'b1, 10);
    chk("steps off", 32'h0, 32'(n));
    chk("stage off", 32'h0, 32'(stage_enable));
    setc(5'h08, 1'b1, 1'b0, 2'h0, 4'h0);
    step1(2'h0, 1'b1, 10);
    chk("low active", 32'h1, 32'(n));
    chk("stage on", 32'h1, 32'(stage_enable));
    @(posedge ref_clk);
    enable_in <= 1'b1;
    setc(5'h08, 1'b1, 1'b1, 2'h0, 4'h0);
  endtask

  task automatic t_fault();
    for (int k = 2; k < 6; k++) begin
      fev(6'(1 << k));
      rdc("fault", sdcc_pkg::ADDR_FAULT, 32'(1 << k));
      bus(1'b1, sdcc_pkg::ADDR_FAULT, 32'h0);
      rdc("fault kept", sdcc_pkg::ADDR_FAULT, 32'(1 << k));
      bus(1'b1, sdcc_pkg::ADDR_DELAY, 32'h01f4);
      rdc("fault clear", sdcc_pkg::ADDR_FAULT, 32'h0);
    end
    fev(6'h03);
    rdc("fault none", sdcc_pkg::ADDR_FAULT, 32'h0);
  endtask

  task automatic t_hold();
    bus(1'b1, sdcc_pkg::ADDR_CURR, 32'h0c28);
    bus(1'b1, sdcc_pkg::ADDR_DELAY, 32'h0);
    step1(2'h0, 1'b1, 10);
    chk("hold pct", 32'h0c, 32'(current_pct));
    bus(1'b1, sdcc_pkg::ADDR_CURR, 32'h0028);
    bus(1'b1, sdcc_pkg::ADDR_DELAY, 32'h1);
    step1(2'h0, 1'b1, 10);
    chk("run", 32'h0, 32'(hold_active));
    chk("run pct", 32'h28, 32'(current_pct));
    repeat (99800) @(negedge ref_clk);
    chk("still run", 32'h0, 32'(hold_active));
    n = 0;
    while (hold_active !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    chk("hold", 32'h1, 32'(hold_active));
    chk("zero pct", 32'h0, 32'(current_pct));
    chk("stage", 32'h0, 32'(stage_enable));
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    t_reset();
    t_microstep_select();
    t_fmt();
    t_filter();
    t_enable();
    t_fault();
    t_hold();
    end_sim();
  end

  initial begin
    repeat (140000) @(posedge ref_clk);
    err_total++;
    end_sim();
  end
endmodule // tb_stepper_drive_config_core
